// *** acc_cfg.svh ***
// Offsets, field positions, reset values and widths of the converter control block
`ifndef ACC_CFG_SVH
`define ACC_CFG_SVH

// ----------------------------------------------------------------
// Register bus
// ----------------------------------------------------------------
`define ACC_ADDR_W 3
`define ACC_DATA_W 16
`define ACC_OFS_CSR 3'h0
`define ACC_OFS_IST 3'h1
`define ACC_OFS_IMSK 3'h2
`define ACC_OFS_RES 3'h3

// ----------------------------------------------------------------
// Control/status register layout
// ----------------------------------------------------------------
`define ACC_CSR_W 8
`define ACC_CSR_RST 8'h00
`define ACC_CSR_FLAG 7
`define ACC_CH_W 4
`define ACC_IDX_W 2

// ----------------------------------------------------------------
// Event bits of the interrupt status and mask registers
// ----------------------------------------------------------------
`define ACC_EVT_W 3
`define ACC_EVT_DONE 0
`define ACC_EVT_CHAN 1
`define ACC_EVT_ABORT 2
`define ACC_EVT_RST 3'h0

// ----------------------------------------------------------------
// Converter core and halt inputs
// ----------------------------------------------------------------
`define ACC_RES_W 10
`define ACC_RES_RST 10'h000
`define ACC_HALT_W 3

`endif

// *** acc_pkg.sv ***
// Types shared by the converter control block
package acc_pkg;

  // ----------------------------------------------------------------
  // Control/status register fields, bit 7 down to bit 0
  // ----------------------------------------------------------------
  typedef struct packed {
    logic conversion_done_flag;  // Bit 7
    logic done_irq_enable;       // Bit 6
    logic conversion_go_bit;     // Bit 5
    logic scanMode;              // Bit 4
    logic [3:0] inputSelect;     // Bits 3..0
  } acc_csr_t;

  // Request to the multiplexer and converter core
  typedef struct packed {
    logic start;       // One-cycle conversion start
    logic abort;       // One-cycle halt of a conversion in flight
    logic [3:0] sel;   // Analog input to convert
  } acc_core_req_t;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_WAIT = 3'b001,
    ST_LAUNCH = 3'b010,
    ST_BUSY = 3'b100
  } acc_state_t;

endpackage

// *** acc_sync.sv ***
// Two-stage synchroniser for asynchronous level inputs
`include "acc_cfg.svh"
module acc_sync #(
  parameter int WIDTH = `ACC_HALT_W
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  // ----------------------------------------------------------------
  // One pair of flops per bit; the first is read only by the second
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic stage1;  // Metastability catcher
      logic stage2;  // Clean level
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          stage1 <= 1'b0;
          stage2 <= 1'b0;
        end else begin
          stage1 <= asyncIn[i];
          stage2 <= stage1;
        end
      end
      assign syncOut[i] = stage2;
    end
  endgenerate

endmodule

// *** acc_chan_seq.sv ***
// Channel pointer: picks the input to convert and marks the last of a pass
`include "acc_cfg.svh"
module acc_chan_seq (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic load,
  input wire logic advance,
  input wire logic scanMode,
  input wire logic [`ACC_CH_W-1:0] chanField,
  output logic [`ACC_CH_W-1:0] curInput,
  output logic passLast
);

  // ----------------------------------------------------------------
  // Position inside the group
  // ----------------------------------------------------------------
  logic [`ACC_IDX_W-1:0] idx;       // Offset from the group base
  logic [`ACC_IDX_W-1:0] next_idx;  // Next offset

  // Last channel of the pass: always in single mode
  assign passLast = !scanMode || (idx == chanField[`ACC_IDX_W-1:0]);

  // Single mode takes the field as it is; scan mode uses the group base plus offset
  assign curInput = scanMode ? {chanField[`ACC_CH_W-1:`ACC_IDX_W], idx} : chanField;

  // Offset steps up and wraps to the group's lowest input after the last
  always_comb begin
    next_idx = idx;
    if (load) begin
      next_idx = '0;
    end else if (advance) begin
      next_idx = passLast ? '0 : idx + 1'b1;
    end
  end

  // Offset register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      idx <= '0;
    end else begin
      idx <= next_idx;
    end
  end

endmodule

// *** acc_ctrl.sv ***
// Converter run, mode and channel control with register port and interrupt
`include "acc_cfg.svh"

module acc_ctrl (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [`ACC_ADDR_W-1:0] regAddr,
  input wire logic [`ACC_DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [`ACC_DATA_W-1:0] regRdData,
  output acc_pkg::acc_core_req_t coreReq,
  input wire logic coreDone,
  input wire logic [`ACC_RES_W-1:0] coreResult,
  input wire logic swStandby,
  input wire logic hwStandby,
  input wire logic moduleStop,
  output logic done_irq_request,
  output logic irq
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  acc_pkg::acc_csr_t converter_control_status;  // Control/status register
  acc_pkg::acc_csr_t next_converter_control_status;
  acc_pkg::acc_csr_t wrCsr;                      // Write data seen as fields
  logic flagSeen;                                // Flag was read as 1
  logic next_flagSeen;
  acc_pkg::acc_state_t state;                    // Sequencer state
  acc_pkg::acc_state_t next_state;
  acc_pkg::acc_core_req_t next_coreReq;
  logic [`ACC_RES_W-1:0] lastResult;             // Most recent conversion
  logic [`ACC_RES_W-1:0] next_lastResult;
  logic [`ACC_EVT_W-1:0] irqStatus;              // Sticky event bits
  logic [`ACC_EVT_W-1:0] next_irqStatus;
  logic [`ACC_EVT_W-1:0] irqMask;                // Event enables
  logic [`ACC_EVT_W-1:0] next_irqMask;
  logic [`ACC_EVT_W-1:0] events;                 // This cycle's events
  logic [`ACC_DATA_W-1:0] next_regRdData;
  logic [`ACC_HALT_W-1:0] haltSync;              // Synchronised halt pins
  logic halt;                                    // Any standby or stop
  logic seqLoad;                                 // Restart the channel pointer
  logic seqAdvance;                              // Step the channel pointer
  logic [`ACC_CH_W-1:0] curInput;                // Input for the next start
  logic seqLast;                                 // Current input ends the pass
  logic startPulse;                              // Launch a conversion
  logic abortPulse;                              // Kill a conversion in flight
  logic chanEvt;                                 // One channel finished
  logic passEvt;                                 // A pass finished
  logic csrWr;                                   // Write to the control register
  logic csrRd;                                   // Read of the control register

  // ----------------------------------------------------------------
  // Halt inputs come from pins and pass two flops first
  // ----------------------------------------------------------------
  acc_sync #(
    .WIDTH(`ACC_HALT_W)
  ) u_halt_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .asyncIn({moduleStop, hwStandby, swStandby}),
    .syncOut(haltSync)
  );

  assign halt = |haltSync;

  // ----------------------------------------------------------------
  // Channel pointer
  // ----------------------------------------------------------------
  acc_chan_seq u_chan_seq (
    .clock(clock),
    .sys_rst(sys_rst),
    .load(seqLoad),
    .advance(seqAdvance),
    .scanMode(converter_control_status.scanMode),
    .chanField(converter_control_status.inputSelect),
    .curInput(curInput),
    .passLast(seqLast)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Decides starts, aborts and completions from the go bit and core
  always_comb begin
    next_state = state;
    seqLoad = 1'b0;
    seqAdvance = 1'b0;
    startPulse = 1'b0;
    abortPulse = 1'b0;
    chanEvt = 1'b0;
    passEvt = 1'b0;
    case (state)
      acc_pkg::ST_WAIT: begin
        // Go set: restart the pointer; a scan starts from the group's lowest input
        if (converter_control_status.conversion_go_bit && !halt) begin
          next_state = acc_pkg::ST_LAUNCH;
          seqLoad = 1'b1;
        end
      end
      acc_pkg::ST_LAUNCH: begin
        if (!converter_control_status.conversion_go_bit || halt) begin
          next_state = acc_pkg::ST_WAIT;
        end else begin
          startPulse = 1'b1;
          next_state = acc_pkg::ST_BUSY;
        end
      end
      acc_pkg::ST_BUSY: begin
        if (!converter_control_status.conversion_go_bit || halt) begin
          // Stop takes priority over a completion in the same cycle
          abortPulse = 1'b1;
          next_state = acc_pkg::ST_WAIT;
        end else if (coreDone) begin
          chanEvt = 1'b1;
          passEvt = seqLast;
          if (converter_control_status.scanMode) begin
            // Next channel, or back to the group base after the last
            seqAdvance = 1'b1;
            next_state = acc_pkg::ST_LAUNCH;
          end else begin
            next_state = acc_pkg::ST_WAIT;
          end
        end
      end
      default: begin
        next_state = acc_pkg::ST_WAIT;
      end
    endcase
  end

  // Sequencer state register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= acc_pkg::ST_WAIT;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Core request and result capture
  // ----------------------------------------------------------------
  // Select is held after the start so the multiplexer stays settled
  always_comb begin
    next_coreReq.start = startPulse;
    next_coreReq.abort = abortPulse;
    next_coreReq.sel = startPulse ? curInput : coreReq.sel;
    next_lastResult = chanEvt ? coreResult : lastResult;
  end

  // Request and result registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      coreReq <= '0;
      lastResult <= `ACC_RES_RST;
    end else begin
      coreReq <= next_coreReq;
      lastResult <= next_lastResult;
    end
  end

  // ----------------------------------------------------------------
  // Control/status register
  // ----------------------------------------------------------------
  assign csrWr = regWr && (regAddr == `ACC_OFS_CSR);
  assign csrRd = regRd && (regAddr == `ACC_OFS_CSR);
  assign wrCsr = acc_pkg::acc_csr_t'(regWrData[`ACC_CSR_W-1:0]);

  // Software fields, hardware clears and the sticky done flag
  always_comb begin
    next_converter_control_status = converter_control_status;
    next_flagSeen = flagSeen;
    // Arm the flag clear only after software has seen it set
    if (csrRd && converter_control_status.conversion_done_flag) begin
      next_flagSeen = 1'b1;
    end
    // Single conversion over: go drops by itself
    if (chanEvt && !converter_control_status.scanMode) begin
      next_converter_control_status.conversion_go_bit = 1'b0;
    end
    // A write after the auto clear, so a fresh go of 1 is kept
    if (csrWr) begin
      next_converter_control_status.done_irq_enable = wrCsr.done_irq_enable;
      next_converter_control_status.conversion_go_bit = wrCsr.conversion_go_bit;
      next_converter_control_status.scanMode = wrCsr.scanMode;
      next_converter_control_status.inputSelect = wrCsr.inputSelect;
      // Writing 1 to the flag has no effect
      if (!wrCsr.conversion_done_flag && flagSeen) begin
        next_converter_control_status.conversion_done_flag = 1'b0;
        next_flagSeen = 1'b0;
      end
    end
    // Set wins over a clear in the same cycle
    if (passEvt) begin
      next_converter_control_status.conversion_done_flag = 1'b1;
    end
    // Standby or module stop forces the go bit low and blocks setting it
    if (halt) begin
      next_converter_control_status.conversion_go_bit = 1'b0;
    end
  end

  // Reset gives single mode on input zero, go and flag low
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      converter_control_status <= acc_pkg::acc_csr_t'(`ACC_CSR_RST);
      flagSeen <= 1'b0;
    end else begin
      converter_control_status <= next_converter_control_status;
      flagSeen <= next_flagSeen;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  always_comb begin
    events = '0;
    events[`ACC_EVT_DONE] = passEvt;
    events[`ACC_EVT_CHAN] = chanEvt;
    events[`ACC_EVT_ABORT] = abortPulse;
  end

  // A read clears the status; an event in that cycle still lands
  always_comb begin
    next_irqStatus = irqStatus;
    next_irqMask = irqMask;
    if (regRd && (regAddr == `ACC_OFS_IST)) begin
      next_irqStatus = '0;
    end
    next_irqStatus = next_irqStatus | events;
    if (regWr && (regAddr == `ACC_OFS_IMSK)) begin
      next_irqMask = regWrData[`ACC_EVT_W-1:0];
    end
  end

  // Status and mask registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irqStatus <= `ACC_EVT_RST;
      irqMask <= `ACC_EVT_RST;
    end else begin
      irqStatus <= next_irqStatus;
      irqMask <= next_irqMask;
    end
  end

  // Both interrupt outputs are built from flops only, so no glitches
  assign irq = |(irqStatus & irqMask);
  assign done_irq_request = converter_control_status.conversion_done_flag
                            && converter_control_status.done_irq_enable;

  // ----------------------------------------------------------------
  // Read data, one cycle after the read strobe
  // ----------------------------------------------------------------
  // Narrow registers sit low; unmapped offsets and idle cycles read zero
  always_comb begin
    next_regRdData = '0;
    if (regRd) begin
      case (regAddr)
        `ACC_OFS_CSR: begin
          next_regRdData = `ACC_DATA_W'(converter_control_status);
        end
        `ACC_OFS_IST: begin
          next_regRdData = `ACC_DATA_W'(irqStatus);
        end
        `ACC_OFS_IMSK: begin
          next_regRdData = `ACC_DATA_W'(irqMask);
        end
        `ACC_OFS_RES: begin
          next_regRdData = `ACC_DATA_W'(lastResult);
        end
        default: begin
          next_regRdData = '0;
        end
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      regRdData <= '0;
    end else begin
      regRdData <= next_regRdData;
    end
  end

endmodule

// *** acc_ctrl_properties.sv ***
// Concurrent checks on the ports of the converter run, mode and channel control
`include "acc_cfg.svh"
module acc_ctrl_properties (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [`ACC_ADDR_W-1:0] regAddr,
  input wire logic [`ACC_DATA_W-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [`ACC_DATA_W-1:0] regRdData,
  input wire acc_pkg::acc_core_req_t coreReq,
  input wire logic coreDone,
  input wire logic [`ACC_RES_W-1:0] coreResult,
  input wire logic swStandby,
  input wire logic hwStandby,
  input wire logic moduleStop,
  input wire logic done_irq_request,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // Helper state
  // ------------------------------------------------------------
  logic inFlight;     // Conversion launched, not yet finished or aborted
  logic [7:0] lastCsr; // Last byte written to the control register
  logic [1:0] quiet;  // Cycles with every halt input low, saturating
  wire logic wrCsr = regWr && (regAddr == `ACC_OFS_CSR);
  wire logic anyHalt = swStandby || hwStandby || moduleStop;
  // First input of a run: scan starts at the bottom of the group
  wire logic [3:0] firstSel = lastCsr[4] ? {lastCsr[3:2], 2'b00} : lastCsr[3:0];

  // Tracks the core link; a halt needs three quiet cycles to clear the synchroniser
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      inFlight <= 1'b0;
      lastCsr <= 8'h00;
      quiet <= 2'h0;
    end else begin
      inFlight <= coreReq.start || (inFlight && !coreDone && !coreReq.abort);
      if (wrCsr) begin
        lastCsr <= regWrData[7:0];
      end
      quiet <= anyHalt ? 2'h0 : ((quiet == 2'h3) ? 2'h3 : quiet + 2'h1);
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking dcb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  start_pulse_a: assert property (coreReq.start |=> !coreReq.start)
    else $error("start pulse wider than one cycle");
  go_launch_a: assert property (wrCsr && regWrData[5] && !inFlight && !$past(inFlight) && !coreReq.start
    && quiet == 2'h3 |-> ##3 (coreReq.start && coreReq.sel == firstSel))
    else $error("go write did not start the selected input");
  single_stop_a: assert property (coreDone && inFlight && !lastCsr[4] && !wrCsr |=> (!coreReq.start) [*4])
    else $error("single mode started again after done");
  scan_repeat_a: assert property (coreDone && inFlight && lastCsr[5] && lastCsr[4] && quiet == 2'h3
    && !wrCsr && !$past(wrCsr) |-> ##2 coreReq.start)
    else $error("scan did not continue after a conversion");
  stop_abort_a: assert property (wrCsr && !regWrData[5] && inFlight && !coreDone |-> ##[1:2] coreReq.abort)
    else $error("stop write gave no abort");
  halt_nostart_a: assert property ((anyHalt) [*4] |-> !coreReq.start)
    else $error("start issued while halted");
  sel_hold_a: assert property (!coreReq.start |-> $stable(coreReq.sel))
    else $error("input select moved without a start");
  request_cause_a: assert property ($rose(done_irq_request) |-> $past(coreDone) || $past(wrCsr))
    else $error("done request rose without a cause");
endmodule

bind acc_ctrl acc_ctrl_properties u_props (
  .clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .coreReq(coreReq), .coreDone(coreDone), .coreResult(coreResult),
  .swStandby(swStandby), .hwStandby(hwStandby), .moduleStop(moduleStop),
  .done_irq_request(done_irq_request), .irq(irq)
);

// *** acc_core_model.sv ***
// Behavioural analog multiplexer and converter core facing the control block
module acc_core_model (
  input wire logic clock,
  input wire logic sys_rst,
  input wire acc_pkg::acc_core_req_t coreReq,
  input wire logic slow,
  output logic coreDone,
  output logic [9:0] coreResult
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy;       // Conversion in progress
  logic [7:0] left; // Cycles before the result is ready
  logic [3:0] held; // Input latched at start

  initial begin
    coreDone = 1'b0;
    coreResult = 10'h000;
  end

  // Done pulses once; the result is only meaningful in that cycle
  always @(posedge clock) begin
    coreDone <= 1'b0;
    coreResult <= ~coreResult; // Not held, so a late sample is caught
    if (sys_rst) begin
      busy <= 1'b0;
      left <= 8'h00;
    end else if (coreReq.abort) begin
      busy <= 1'b0;
    end else if (coreReq.start) begin
      busy <= 1'b1;
      left <= slow ? 8'h0c : 8'h02;
      held <= coreReq.sel;
    end else if (busy) begin
      if (left == 8'h00) begin
        busy <= 1'b0;
        coreDone <= 1'b1;
        coreResult <= {6'h2b, held};
      end else begin
        left <= left - 8'h01;
      end
    end
  end
endmodule

// *** adc_start_mode_channel_ctrl_tb.sv ***
// Self-checking testbench for the converter run, mode and channel control
module adc_start_mode_channel_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // Signals and instances
  // ------------------------------------------------------------
  logic clock, sys_rst, regWr, regRd, coreDone, swStandby, hwStandby, moduleStop;
  logic done_irq_request, irq, slow;
  logic [2:0] regAddr;
  logic [15:0] regWrData, regRdData;
  logic [9:0] coreResult;
  acc_pkg::acc_core_req_t coreReq;
  int errCount = 0;
  int checkCount = 0;

  acc_ctrl u_dut (.clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .coreReq(coreReq), .coreDone(coreDone), .coreResult(coreResult),
    .swStandby(swStandby), .hwStandby(hwStandby), .moduleStop(moduleStop),
    .done_irq_request(done_irq_request), .irq(irq));
  acc_core_model u_core (.clock(clock), .sys_rst(sys_rst), .coreReq(coreReq), .slow(slow),
    .coreDone(coreDone), .coreResult(coreResult));

  always #25 clock = ~clock;

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checkCount, errCount);
    if (errCount == 0 && checkCount > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
    checkCount++;
    if (g !== e) begin
      errCount++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask

  // Bus cycles: strobe for one cycle, data sampled in the following cycle
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    @(negedge clock);
    d = regRdData;
  endtask

  // Bounded wait for a start or abort pulse towards the core
  task automatic wait_req(input logic ab, output logic [3:0] s);
    int i;
    for (i = 0; i < 300; i++) begin
      @(negedge clock);
      if ((ab ? coreReq.abort : coreReq.start) === 1'b1) break;
    end
    if (i == 300) begin
      errCount++;
      $display("CHECK FAILED at %0t: no core request", $time);
      summarize();
    end
    s = coreReq.sel;
  endtask

  // Bounded poll until the go bit reads back low
  task automatic poll_idle(output logic [15:0] d);
    int i;
    for (i = 0; i < 60; i++) begin
      rd(3'h0, d);
      if (d[5] === 1'b0) break;
    end
    if (i == 60) begin
      errCount++;
      $display("CHECK FAILED at %0t: go bit stuck", $time);
      summarize();
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [15:0] d;
    rd(3'h0, d);
    chk(d, 16'h0000, "control after reset");
    rd(3'h1, d);
    chk(d, 16'h0000, "status after reset");
    rd(3'h6, d);
    chk(d, 16'h0000, "unmapped read");
    $display("Test reset done");
  endtask

  // Every input once in single mode; masked interrupt first
  task automatic t_single();
    logic [15:0] d;
    logic [3:0] s, ch;
    wr(3'h2, 16'h0000);
    wr(3'h0, 16'h0061);
    wait_req(1'b0, s);
    poll_idle(d);
    chk(16'(irq), 16'h0000, "irq while masked");
    chk(16'(done_irq_request), 16'h0001, "done request");
    wr(3'h2, 16'h0007);
    @(negedge clock);
    chk(16'(irq), 16'h0001, "irq unmasked");
    rd(3'h2, d);
    chk(d, 16'h0007, "mask readback");
    rd(3'h1, d);
    chk(d, 16'h0003, "status events");
    chk(16'(irq), 16'h0000, "irq after status read");
    for (int c = 0; c < 16; c++) begin
      ch = 4'(c);
      wr(3'h0, {9'h000, ch[0], 1'b1, 1'b0, ch});
      wait_req(1'b0, s);
      chk(16'(s), 16'(ch), "single input");
      poll_idle(d);
      chk(d, {8'h00, 1'b1, ch[0], 2'b00, ch}, "control after single");
      chk(16'(done_irq_request), 16'(ch[0]), "done request");
      rd(3'h3, d);
      chk(d, {6'h00, 6'h2b, ch}, "result");
      rd(3'h1, d);
      chk(d, 16'h0003, "status");
    end
    wr(3'h0, 16'h0000);
    rd(3'h0, d);
    chk(d, 16'h0000, "flag cleared");
    $display("Test single done");
  endtask

  // Each group with one to four inputs, two passes, then a stop in mid-conversion
  task automatic t_scan();
    logic [15:0] d;
    logic [3:0] s, ch;
    slow <= 1'b1;
    for (int g = 0; g < 4; g++) begin
      ch = {2'(g), 2'(g)};
      wr(3'h0, {8'h00, 4'h3, ch});
      for (int k = 0; k < 2 * (g + 1); k++) begin
        wait_req(1'b0, s);
        chk(16'(s), 16'(4 * g + k % (g + 1)), "scan input");
      end
      rd(3'h0, d);
      chk(16'(d[7]), 16'h0001, "pass flag");
      wr(3'h0, {8'h00, 4'h1, ch});
      wait_req(1'b1, s);
      poll_idle(d);
      rd(3'h1, d);
      chk(16'(d[2]), 16'h0001, "abort event");
    end
    $display("Test scan done");
  endtask

  // Each halt input stops a scan; then a reset in mid-run
  task automatic t_halt();
    logic [15:0] d;
    logic [3:0] s;
    int n;
    for (int h = 0; h < 3; h++) begin
      wr(3'h0, 16'h0033);
      wait_req(1'b0, s);
      @(posedge clock);
      {swStandby, hwStandby, moduleStop} <= 3'b100 >> h;
      repeat (6) @(negedge clock);
      n = 0;
      repeat (25) begin
        @(negedge clock);
        n += (coreReq.start === 1'b1);
      end
      rd(3'h0, d);
      chk(16'(d[5]), 16'h0000, "go after halt");
      chk(16'(n), 16'h0000, "starts while halted");
      @(posedge clock);
      {swStandby, hwStandby, moduleStop} <= 3'b000;
      repeat (4) @(posedge clock);
    end
    wr(3'h0, 16'h0033);
    wait_req(1'b0, s);
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    rd(3'h0, d);
    chk(d, 16'h0000, "control after reset");
    $display("Test halt done");
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    regAddr = 3'h0;
    regWrData = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    swStandby = 1'b0;
    hwStandby = 1'b0;
    moduleStop = 1'b0;
    slow = 1'b0;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    t_reset();
    t_single();
    t_scan();
    t_halt();
    summarize();
  end
endmodule
